// *** common/amgc_defs.svh ***
`ifndef AMGC_DEFS_SVH
`define AMGC_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define AMGC_IDX_CONV_MUX      6'h15
`define AMGC_IDX_DIAG_MUX      6'h16
`define AMGC_IDX_PIN_DIR       6'h17
`define AMGC_IDX_PIN_LEVEL     6'h18
`define AMGC_IDX_REFBUF        6'h19
`define AMGC_IDX_PRECHARGE     6'h1A
`define AMGC_IDX_OFFSET_HIGH   6'h1C
`define AMGC_IDX_OFFSET_MIDDLE 6'h1D
`define AMGC_IDX_OFFSET_LOW    6'h1E
`define AMGC_IDX_SCALE_HIGH    6'h1F
`define AMGC_IDX_SCALE_MIDDLE  6'h20
`define AMGC_IDX_SCALE_LOW     6'h21
`define AMGC_IDX_FIRST         6'h15
`define AMGC_IDX_LAST          6'h21

// reset values
`define AMGC_RST_ZERO          8'h00
`define AMGC_RST_REFBUF        8'h38
`define AMGC_RST_PRECHARGE     8'hC0

// writable bits of each register
`define AMGC_MASK_CONV_MUX     8'hFC
`define AMGC_MASK_DIAG_MUX     8'hF8
`define AMGC_MASK_PIN_DIR      8'h07
`define AMGC_MASK_PIN_LEVEL    8'h07
`define AMGC_MASK_REFBUF       8'h18
`define AMGC_MASK_PRECHARGE    8'hC7
`define AMGC_MASK_FULL         8'hFF

// field positions
`define AMGC_REF_MSB           7
`define AMGC_REF_LSB           6
`define AMGC_METER_MSB         5
`define AMGC_METER_LSB         2
`define AMGC_DIAG_MSB          7
`define AMGC_DIAG_LSB          3
`define AMGC_PIN_IN_MSB        5
`define AMGC_PIN_IN_LSB        3
`define AMGC_PIN_OUT_MSB       2
`define AMGC_PIN_OUT_LSB       0
`define AMGC_POS_BUF_BIT       4
`define AMGC_NEG_BUF_BIT       3
`define AMGC_POS_PRE_BIT       7
`define AMGC_NEG_PRE_BIT       6
`define AMGC_OVR_A1_BIT        2
`define AMGC_OVR_A2_BIT        1
`define AMGC_OVR_D_BIT         0

// legal code ranges
`define AMGC_METER_LOW         4'h2
`define AMGC_METER_HIGH        4'h9
`define AMGC_METER_FIXED       4'h2
`define AMGC_DIAG_LOW          5'h00
`define AMGC_DIAG_HIGH         5'h15

`endif

// *** common/amgc_pkg.sv ***
package amgc_pkg;

  // reference source of the converter
  typedef enum logic [1:0] {
    AMGC_REF_EXT_NORMAL  = 2'h0,
    AMGC_REF_INTERNAL    = 2'h1,
    AMGC_REF_SUPPLY      = 2'h2,
    AMGC_REF_EXT_SWAPPED = 2'h3
  } amgc_ref_t;

  // bus transfer kinds
  typedef enum logic [1:0] {
    AMGC_TRANS_IDLE   = 2'h0,
    AMGC_TRANS_BUSY   = 2'h1,
    AMGC_TRANS_NONSEQ = 2'h2,
    AMGC_TRANS_SEQ    = 2'h3
  } amgc_trans_t;

  typedef logic [7:0] amgc_byte_t;

endpackage

// *** logic/amgc_sync.sv ***
`timescale 1ns/10ps
// ************************************************
// two-stage synchroniser, one chain per bit
// ************************************************
module amgc_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  if (WIDTH < 1) begin : gBadWidth
    $error("amgc_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] firstStage;

  // first stage feeds only the second stage
  for (genvar b = 0; b < WIDTH; b++) begin : gBit
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        firstStage[b] <= 1'b0;
        syncOut[b]    <= 1'b0;
      end else begin
        firstStage[b] <= asyncIn[b];
        syncOut[b]    <= firstStage[b];
      end
    end
  end

endmodule

// *** logic/amgc_range_flag.sv ***
`timescale 1ns/10ps
// ************************************************
// registered flag: code lies within a legal range
// ************************************************
module amgc_range_flag #(
  parameter int               WIDTH = 4,
  parameter logic [WIDTH-1:0] LOW   = '0,
  parameter logic [WIDTH-1:0] HIGH  = '1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] code,
  output logic                  inRange
);

  if (LOW > HIGH) begin : gBadRange
    $error("amgc_range_flag: LOW above HIGH");
  end

  // one cycle behind the code
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inRange <= 1'b0;
    end else begin
      inRange <= (code >= LOW) && (code <= HIGH);
    end
  end

endmodule

// *** logic/amgc_regs.sv ***
`timescale 1ns/10ps
`include "amgc_defs.svh"

// Summary of operation
// - top two bits pick the reference, next four pick the meter input
// - diagnostic select in bits seven to three, codes 00000 to 10101 legal
// - three low direction bits set each pin output or input, reset cleared
// - pin level bits five to three return sampled pins, read only
// - three low level bits drive the pins, read-write, reset zero
// - bit four positive, bit three negative buffer enable, reset 0x38
// - bit seven and six enable buffer precharge, set after reset
// - bits two to zero enable regulator overdrives, cleared, register resets 0xC0
// - offset word 24 bits in three bytes, high byte lowest address
// - scale word high byte first, middle byte next, read-write, zero
// - scale word low byte follows the middle byte, reset zero
module amgc_regs
  import amgc_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int PIN_COUNT  = 3
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [ADDR_WIDTH-1:0] haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic [PIN_COUNT-1:0]  pinLevelIn,
  output logic [PIN_COUNT-1:0]       pinLevelOut,
  output logic [PIN_COUNT-1:0]       pinOutputEnable,
  output amgc_ref_t                  referenceSelect,
  output logic [3:0]                 meterInputSelect,
  output logic                       meterCodeLegal,
  output logic                       meterFixedLevel,
  output logic [4:0]                 diagnosticInputSelect,
  output logic                       diagnosticCodeLegal,
  output logic                       positiveRefbufferOn,
  output logic                       negativeRefbufferOn,
  output logic                       positiveRefbufferPrecharge,
  output logic                       negativeRefbufferPrecharge,
  output logic                       analogRegulator1Overdrive,
  output logic                       analogRegulator2Overdrive,
  output logic                       digitalRegulatorOverdrive,
  output logic [23:0]                chan0OffsetWord,
  output logic [23:0]                chan0ScaleWord
);

  // ************************************************
  // parameter checks and local constants
  // ************************************************
  // one byte slot per index 0x15 to 0x21
  localparam int NUM_REGS = 13;

  // refuse widths the decode cannot serve
  if (ADDR_WIDTH < 8) begin : gBadAddr
    $error("amgc_regs: ADDR_WIDTH must be at least 8");
  end
  if (PIN_COUNT != 3) begin : gBadPins
    $error("amgc_regs: exactly three pins are served");
  end

  // mux slots
  localparam logic [3:0] SLOT_CONV_MUX  = 4'(`AMGC_IDX_CONV_MUX - `AMGC_IDX_FIRST);
  localparam logic [3:0] SLOT_DIAG_MUX  = 4'(`AMGC_IDX_DIAG_MUX - `AMGC_IDX_FIRST);

  // pin slots
  localparam logic [3:0] SLOT_PIN_DIR   = 4'(`AMGC_IDX_PIN_DIR - `AMGC_IDX_FIRST);
  localparam logic [3:0] SLOT_PIN_LEVEL = 4'(`AMGC_IDX_PIN_LEVEL - `AMGC_IDX_FIRST);

  // buffer slots
  localparam logic [3:0] SLOT_REFBUF    = 4'(`AMGC_IDX_REFBUF - `AMGC_IDX_FIRST);
  localparam logic [3:0] SLOT_PRECHARGE = 4'(`AMGC_IDX_PRECHARGE - `AMGC_IDX_FIRST);

  // offset slots
  localparam logic [3:0] SLOT_OFS_HIGH  = 4'(`AMGC_IDX_OFFSET_HIGH - `AMGC_IDX_FIRST);
  localparam logic [3:0] SLOT_OFS_MID   = 4'(`AMGC_IDX_OFFSET_MIDDLE - `AMGC_IDX_FIRST);
  localparam logic [3:0] SLOT_OFS_LOW   = 4'(`AMGC_IDX_OFFSET_LOW - `AMGC_IDX_FIRST);

  // scale slots
  localparam logic [3:0] SLOT_SCL_HIGH  = 4'(`AMGC_IDX_SCALE_HIGH - `AMGC_IDX_FIRST);
  localparam logic [3:0] SLOT_SCL_MID   = 4'(`AMGC_IDX_SCALE_MIDDLE - `AMGC_IDX_FIRST);
  localparam logic [3:0] SLOT_SCL_LOW   = 4'(`AMGC_IDX_SCALE_LOW - `AMGC_IDX_FIRST);

  // ************************************************
  // per-slot writable masks and reset values
  // ************************************************

  // unlisted slots (the gap between buffer and offset) hold nothing
  function automatic amgc_byte_t maskOf(input logic [3:0] slot);
    amgc_byte_t m;
    m = 8'h00;
    unique case (slot)
      SLOT_CONV_MUX:  m = `AMGC_MASK_CONV_MUX;
      SLOT_DIAG_MUX:  m = `AMGC_MASK_DIAG_MUX;
      SLOT_PIN_DIR:   m = `AMGC_MASK_PIN_DIR;
      SLOT_PIN_LEVEL: m = `AMGC_MASK_PIN_LEVEL;
      SLOT_REFBUF:    m = `AMGC_MASK_REFBUF;
      SLOT_PRECHARGE: m = `AMGC_MASK_PRECHARGE;
      SLOT_OFS_HIGH,
      SLOT_OFS_MID,
      SLOT_OFS_LOW:   m = `AMGC_MASK_FULL;
      SLOT_SCL_HIGH,
      SLOT_SCL_MID:   m = `AMGC_MASK_FULL;
      SLOT_SCL_LOW:   m = `AMGC_MASK_FULL;
      default:        m = 8'h00;
    endcase
    return m;
  endfunction

  // reset value of every slot
  function automatic amgc_byte_t resetOf(input logic [3:0] slot);
    amgc_byte_t r;
    r = `AMGC_RST_ZERO;
    if (slot == SLOT_REFBUF) begin
      r = `AMGC_RST_REFBUF;
    end else if (slot == SLOT_PRECHARGE) begin
      r = `AMGC_RST_PRECHARGE;
    end
    return r;
  endfunction

  // ************************************************
  // address phase decode
  // ************************************************
  logic [ADDR_WIDTH-3:0] addrIndex;
  logic                  addrPhase;
  logic                  addrMapped;
  logic [3:0]            addrSlot;
  logic                  rdRequest;
  logic                  wrRequest;

  // a transfer is taken when selected, ready and NONSEQ or SEQ
  assign addrIndex = haddr[ADDR_WIDTH-1:2];
  assign addrPhase = hsel && hready && htrans[1];
  assign addrSlot  = 4'(addrIndex - (ADDR_WIDTH-2)'(`AMGC_IDX_FIRST));

  // read and write requests
  assign rdRequest = addrPhase && !hwrite;
  assign wrRequest = addrPhase && hwrite;

  // word-aligned addresses inside the block only
  always_comb begin
    addrMapped = (haddr[1:0] == 2'h0)
              && (addrIndex >= (ADDR_WIDTH-2)'(`AMGC_IDX_FIRST))
              && (addrIndex <= (ADDR_WIDTH-2)'(`AMGC_IDX_LAST));
  end

  // ************************************************
  // data phase state of a pending write
  // ************************************************
  logic       wrPending;
  logic [3:0] wrSlot;

  // capture a mapped write; its data arrives next cycle
  // an unmapped write leaves nothing pending
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wrPending <= 1'b0;
      wrSlot    <= 4'h0;
    end else begin
      wrPending <= wrRequest && addrMapped;
      if (wrRequest) begin
        wrSlot <= addrSlot;
      end
    end
  end

  // ************************************************
  // register bank
  // ************************************************
  // slot 6, the gap, always holds zero
  amgc_byte_t regBank [NUM_REGS];

  // each slot loads the masked low byte of the write data
  for (genvar i = 0; i < NUM_REGS; i++) begin : gSlot
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        regBank[i] <= resetOf(4'(i));
      end else if (wrPending && (wrSlot == 4'(i))) begin
        regBank[i] <= hwdata[7:0] & maskOf(4'(i));
      end
    end
  end

  // ************************************************
  // pin sampling
  // ************************************************
  logic [PIN_COUNT-1:0] pinSampled;

  // two flops before any logic reads a pin
  amgc_sync #(
    .WIDTH (PIN_COUNT)
  ) uPinSync (
    .clock   (clock),
    .rst     (rst),
    .asyncIn (pinLevelIn),
    .syncOut (pinSampled)
  );

  // ************************************************
  // read path with forwarding of a write in flight
  // ************************************************
  amgc_byte_t storedByte;
  amgc_byte_t readByte;

  // a read right behind a write to the same slot sees the new value
  always_comb begin
    // a write still in its data phase wins
    storedByte = regBank[addrSlot];
    if (wrPending && (wrSlot == addrSlot)) begin
      storedByte = hwdata[7:0] & maskOf(addrSlot);
    end

    // only mapped slots return data
    readByte = 8'h00;
    if (addrMapped) begin
      readByte = storedByte; // reserved bits read as zero, except refbuffer bit 5, which reads one from reset until written
      if (addrSlot == SLOT_PIN_LEVEL) begin
        readByte[`AMGC_PIN_IN_MSB:`AMGC_PIN_IN_LSB] = pinSampled;
      end
    end
  end

  // read data registered at the address phase, zero otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (rdRequest) begin
      hrdata <= {24'h000000, readByte};
    end else begin
      hrdata <= 32'h00000000;
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ************************************************
  // converter and diagnostic selections
  // ************************************************

  // reference in bits 7:6
  assign referenceSelect  = amgc_ref_t'(regBank[SLOT_CONV_MUX][`AMGC_REF_MSB:`AMGC_REF_LSB]);

  // meter input in bits 5:2
  assign meterInputSelect = regBank[SLOT_CONV_MUX][`AMGC_METER_MSB:`AMGC_METER_LSB];

  // meter code flagged legal within 0010 to 1001
  amgc_range_flag #(
    .WIDTH (4),
    .LOW   (`AMGC_METER_LOW),
    .HIGH  (`AMGC_METER_HIGH)
  ) uMeterRange (
    .clock   (clock),
    .rst     (rst),
    .code    (meterInputSelect),
    .inRange (meterCodeLegal)
  );

  // fixed millivolt level selected
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meterFixedLevel <= 1'b0;
    end else begin
      meterFixedLevel <= (meterInputSelect == `AMGC_METER_FIXED);
    end
  end

  // diagnostic pair select in bits 7:3
  assign diagnosticInputSelect = regBank[SLOT_DIAG_MUX][`AMGC_DIAG_MSB:`AMGC_DIAG_LSB];

  // diagnostic code flagged legal within 00000 to 10101
  amgc_range_flag #(
    .WIDTH (5),
    .LOW   (`AMGC_DIAG_LOW),
    .HIGH  (`AMGC_DIAG_HIGH)
  ) uDiagRange (
    .clock   (clock),
    .rst     (rst),
    .code    (diagnosticInputSelect),
    .inRange (diagnosticCodeLegal)
  );

  // ************************************************
  // general-purpose pins
  // ************************************************

  // direction bit high drives the pin
  assign pinOutputEnable = regBank[SLOT_PIN_DIR][PIN_COUNT-1:0];

  // levels driven onto the pins
  assign pinLevelOut     = regBank[SLOT_PIN_LEVEL][`AMGC_PIN_OUT_MSB:`AMGC_PIN_OUT_LSB];

  // ************************************************
  // reference buffers and regulators
  // ************************************************

  // buffer enables
  assign positiveRefbufferOn        = regBank[SLOT_REFBUF][`AMGC_POS_BUF_BIT];
  assign negativeRefbufferOn        = regBank[SLOT_REFBUF][`AMGC_NEG_BUF_BIT];

  // precharge enables
  assign positiveRefbufferPrecharge = regBank[SLOT_PRECHARGE][`AMGC_POS_PRE_BIT];
  assign negativeRefbufferPrecharge = regBank[SLOT_PRECHARGE][`AMGC_NEG_PRE_BIT];

  // regulator overdrives
  assign analogRegulator1Overdrive  = regBank[SLOT_PRECHARGE][`AMGC_OVR_A1_BIT];
  assign analogRegulator2Overdrive  = regBank[SLOT_PRECHARGE][`AMGC_OVR_A2_BIT];
  assign digitalRegulatorOverdrive  = regBank[SLOT_PRECHARGE][`AMGC_OVR_D_BIT];

  // ************************************************
  // channel 0 calibration words
  // ************************************************

  // high byte at the lowest address
  assign chan0OffsetWord = {
    regBank[SLOT_OFS_HIGH],
    regBank[SLOT_OFS_MID],
    regBank[SLOT_OFS_LOW]
  };

  // scale word in the same byte order
  assign chan0ScaleWord = {
    regBank[SLOT_SCL_HIGH],
    regBank[SLOT_SCL_MID],
    regBank[SLOT_SCL_LOW]
  };

endmodule

// *** dv/amgc_regs_props.sv ***
`timescale 1ns/10ps
`include "amgc_defs.svh"
// ************************************************
// port checker of the register bank
// ************************************************
module amgc_regs_props
  import amgc_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  hsel,
  input wire logic [ADDR_WIDTH-1:0] haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  input wire logic [2:0]            pinLevelIn,
  input wire logic [2:0]            pinLevelOut,
  input wire logic [2:0]            pinOutputEnable,
  input wire amgc_ref_t             referenceSelect,
  input wire logic [3:0]            meterInputSelect,
  input wire logic                  meterCodeLegal,
  input wire logic                  meterFixedLevel,
  input wire logic [4:0]            diagnosticInputSelect,
  input wire logic                  diagnosticCodeLegal,
  input wire logic                  positiveRefbufferOn,
  input wire logic                  negativeRefbufferOn,
  input wire logic                  positiveRefbufferPrecharge,
  input wire logic                  negativeRefbufferPrecharge,
  input wire logic                  analogRegulator1Overdrive,
  input wire logic                  analogRegulator2Overdrive,
  input wire logic                  digitalRegulatorOverdrive,
  input wire logic [23:0]           chan0OffsetWord,
  input wire logic [23:0]           chan0ScaleWord
);
  logic        aphWr, aphRd;
  logic [5:0]  aphIdx;
  logic [2:0]  pinPrev, pinQuiet;
  wire  [47:0] calWord = {chan0OffsetWord, chan0ScaleWord};
  // address phase taken at each edge, unaligned marked unmapped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aphWr  <= 1'b0;
      aphRd  <= 1'b0;
      aphIdx <= 6'h3F;
    end else begin
      aphWr  <= hsel && hready && htrans[1] && hwrite;
      aphRd  <= hsel && hready && htrans[1] && !hwrite;
      aphIdx <= (haddr[1:0] == 2'h0) ? 6'(haddr >> 2) : 6'h3F;
    end
  end
  // cycles for which the pins have stayed still
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinPrev  <= 3'h0;
      pinQuiet <= 3'h0;
    end else begin
      pinPrev  <= pinLevelIn;
      pinQuiet <= (pinLevelIn != pinPrev) ? 3'h0 : ((pinQuiet == 3'h7) ? 3'h7 : pinQuiet + 3'h1);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_conv;
    aphWr && aphIdx == `AMGC_IDX_CONV_MUX |=>
      referenceSelect == $past(hwdata[7:6]) && meterInputSelect == $past(hwdata[5:2]);
  endproperty
  a_conv: assert property (p_conv) else $error("converter select not loaded");
  property p_meter_flags;
    1 |=> meterCodeLegal == ($past(meterInputSelect) >= 4'h2 && $past(meterInputSelect) <= 4'h9) &&
      meterFixedLevel == ($past(meterInputSelect) == 4'h2);
  endproperty
  a_meter_flags: assert property (p_meter_flags) else $error("meter flags wrong");
  property p_diag;
    aphWr && aphIdx == `AMGC_IDX_DIAG_MUX |=> diagnosticInputSelect == $past(hwdata[7:3]);
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic select not loaded");
  property p_diag_flag;
    1 |=> diagnosticCodeLegal == ($past(diagnosticInputSelect) <= 5'h15);
  endproperty
  a_diag_flag: assert property (p_diag_flag) else $error("diagnostic flag wrong");
  property p_pin_dir;
    aphWr && aphIdx == `AMGC_IDX_PIN_DIR |=> pinOutputEnable == $past(hwdata[2:0]);
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction not loaded");
  property p_pin_out;
    aphWr && aphIdx == `AMGC_IDX_PIN_LEVEL |=> pinLevelOut == $past(hwdata[2:0]);
  endproperty
  a_pin_out: assert property (p_pin_out) else $error("pin level not loaded");
  property p_pin_read;
    aphRd && aphIdx == `AMGC_IDX_PIN_LEVEL && pinQuiet >= 3'h5 |-> hrdata == {26'h0, pinLevelIn, pinLevelOut};
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");
  property p_refbuf;
    aphWr && aphIdx == `AMGC_IDX_REFBUF |=>
      positiveRefbufferOn == $past(hwdata[4]) && negativeRefbufferOn == $past(hwdata[3]);
  endproperty
  a_refbuf: assert property (p_refbuf) else $error("buffer enables not loaded");
  property p_precharge;
    aphWr && aphIdx == `AMGC_IDX_PRECHARGE |=> {positiveRefbufferPrecharge, negativeRefbufferPrecharge,
      analogRegulator1Overdrive, analogRegulator2Overdrive, digitalRegulatorOverdrive} ==
      {$past(hwdata[7:6]), $past(hwdata[2:0])};
  endproperty
  a_precharge: assert property (p_precharge) else $error("precharge or overdrive not loaded");
  property p_cal;
    aphWr && aphIdx >= `AMGC_IDX_OFFSET_HIGH && aphIdx <= `AMGC_IDX_SCALE_LOW |=>
      8'(calWord >> (8 * (`AMGC_IDX_SCALE_LOW - $past(aphIdx)))) == $past(hwdata[7:0]);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration byte misplaced");
  property p_read_zero;
    (!aphRd || aphIdx < `AMGC_IDX_FIRST || aphIdx > `AMGC_IDX_LAST || aphIdx == 6'h1B) |->
      hrdata == 32'h0 && hreadyout && !hresp;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("unmapped read not zero");
  c_conv: cover property (aphWr && aphIdx == `AMGC_IDX_CONV_MUX);
  c_pin_read: cover property (aphRd && aphIdx == `AMGC_IDX_PIN_LEVEL && pinQuiet >= 3'h5);
  c_unmapped: cover property (aphRd && aphIdx == 6'h3F);
endmodule

bind amgc_regs amgc_regs_props #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (
  .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .pinLevelIn(pinLevelIn), .pinLevelOut(pinLevelOut), .pinOutputEnable(pinOutputEnable),
  .referenceSelect(referenceSelect), .meterInputSelect(meterInputSelect),
  .meterCodeLegal(meterCodeLegal), .meterFixedLevel(meterFixedLevel),
  .diagnosticInputSelect(diagnosticInputSelect), .diagnosticCodeLegal(diagnosticCodeLegal),
  .positiveRefbufferOn(positiveRefbufferOn), .negativeRefbufferOn(negativeRefbufferOn),
  .positiveRefbufferPrecharge(positiveRefbufferPrecharge),
  .negativeRefbufferPrecharge(negativeRefbufferPrecharge),
  .analogRegulator1Overdrive(analogRegulator1Overdrive), .analogRegulator2Overdrive(analogRegulator2Overdrive),
  .digitalRegulatorOverdrive(digitalRegulatorOverdrive), .chan0OffsetWord(chan0OffsetWord),
  .chan0ScaleWord(chan0ScaleWord)
);

// *** dv/adc_mux_gpio_calib_regs_bench.sv ***
`timescale 1ns/10ps
// ************************************************
// register bank bench over the host bus
// ************************************************
module adc_mux_gpio_calib_regs_bench
  import amgc_pkg::*;
;
  logic        clock, rst, hsel, hwrite, hreadyout, hresp, smpRdy;
  logic        meterCodeLegal, meterFixedLevel, diagnosticCodeLegal, digitalRegulatorOverdrive;
  logic        positiveRefbufferOn, negativeRefbufferOn, positiveRefbufferPrecharge;
  logic        negativeRefbufferPrecharge, analogRegulator1Overdrive, analogRegulator2Overdrive;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pinLevelIn, pinLevelOut, pinOutputEnable;
  logic [3:0]  meterInputSelect;
  logic [4:0]  diagnosticInputSelect;
  logic [7:0]  haddr;
  logic [23:0] chan0OffsetWord, chan0ScaleWord;
  logic [31:0] hwdata, hrdata, smpData, rd;
  amgc_ref_t   referenceSelect;
  int          n_mismatch, compares;
  wire         hready = hreadyout;

  amgc_regs dut (.*);

  // free-running clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // values seen by the master at each rising edge
  always @(posedge clock) begin
    smpRdy <= hready;
    smpData <= hrdata;
  end

  task automatic end_of_test();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one edge at a time until the slave is ready, bounded
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (smpRdy !== 1'b1 && n < 50);
    if (smpRdy !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  // single word transfer: address phase, then data phase
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= adr;
    htrans <= 2'h2;
    hwrite <= wr;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = smpData;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    xfer(1'b1, {idx, 2'b00}, wd);
  endtask
  task automatic rdChk(input logic [5:0] idx, input logic [31:0] exp);
    xfer(1'b0, {idx, 2'b00}, 32'h0);
    compare(rd, exp);
  endtask
  task automatic doReset();
    rst <= 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  function automatic logic [31:0] maskOf(input int i);
    case (i)
      21: return 32'hFC;
      22: return 32'hF8;
      23, 24: return 32'h07;
      25: return 32'h18;
      26: return 32'hC7;
      27: return 32'h00;
      default: return 32'hFF;
    endcase
  endfunction

  // main sequence
  initial begin
    {rst, hsel, hwrite, htrans, haddr, hwdata, pinLevelIn} = '0;
    hsize = 3'h2;
    n_mismatch = 0;
    compares = 0;
    doReset();
    compare({positiveRefbufferOn, negativeRefbufferOn, positiveRefbufferPrecharge, negativeRefbufferPrecharge,
      analogRegulator1Overdrive, analogRegulator2Overdrive, digitalRegulatorOverdrive,
      pinOutputEnable, pinLevelOut}, 32'h1E00);
    for (int i = 21; i <= 33; i++)
      rdChk(6'(i), (i == 25) ? 32'h38 : ((i == 26) ? 32'hC0 : 32'h0));
    for (int i = 21; i <= 33; i++) begin
      wr(6'(i), maskOf(i) | ((i == 24) ? 32'h38 : 32'h0));
      rdChk(6'(i), maskOf(i));
    end
    for (int i = 28; i <= 33; i++)
      wr(6'(i), 32'((i - 27) * 17));
    compare(chan0OffsetWord, 32'h112233);
    compare(chan0ScaleWord, 32'h445566);
    for (int m = 0; m < 16; m++) begin
      wr(6'd21, 32'({m[1:0], m[3:0], 2'b00}));
      compare({referenceSelect, meterInputSelect}, 32'({m[1:0], m[3:0]}));
      @(posedge clock);
      #1;
      compare({meterCodeLegal, meterFixedLevel}, {m >= 2 && m <= 9, m == 2});
    end
    for (int c = 0; c < 32; c++) begin
      wr(6'd22, 32'({c[4:0], 3'b000}));
      compare(diagnosticInputSelect, 32'(c[4:0]));
      @(posedge clock);
      #1;
      compare(diagnosticCodeLegal, c <= 21);
    end
    wr(6'd23, 32'h5);
    compare(pinOutputEnable, 32'h5);
    wr(6'd24, 32'h3A);
    compare(pinLevelOut, 32'h2);
    for (int p = 1; p < 8; p += 5) begin
      pinLevelIn <= 3'(p);
      repeat (6) @(posedge clock);
      #1;
      rdChk(6'd24, 32'({p[2:0], 3'h2}));
    end
    wr(6'd25, 32'h08);
    compare({positiveRefbufferOn, negativeRefbufferOn}, 32'h1);
    rdChk(6'd25, 32'h08);
    wr(6'd26, 32'h45);
    compare({positiveRefbufferPrecharge, negativeRefbufferPrecharge, analogRegulator1Overdrive,
      analogRegulator2Overdrive, digitalRegulatorOverdrive}, 32'h0D);
    xfer(1'b1, 8'h6C, 32'hFF);
    xfer(1'b1, 8'h88, 32'hFF);
    xfer(1'b1, 8'h65, 32'h0);
    rdChk(6'd27, 32'h0);
    rdChk(6'd34, 32'h0);
    xfer(1'b0, 8'h65, 32'h0);
    compare(rd, 32'h0);
    rdChk(6'd25, 32'h08);
    doReset();
    rdChk(6'd25, 32'h38);
    rdChk(6'd26, 32'hC0);
    rdChk(6'd28, 32'h0);
    end_of_test();
  end
endmodule
